// ==== shared/reoml_pkg.sv ====
// Purpose: shared constants for the relay element output mask logic
// Assumes: APB register map with 32-bit data, one word per register
// Notes: curve coefficients are scaled to quarter cycles at 60 Hz
package reoml_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int MAG_W = 16;
	localparam int WORD_W = 8;
	localparam int NUM_OUTS = 4;
	localparam int COEF_W = 20;
	localparam int COEF_FRAC = 8;
	localparam int TD_W = 8;
	localparam int TD_FRAC = 4;
	localparam int LIM_SHIFT = COEF_FRAC + TD_FRAC;
	localparam int ACC_W = 64 - LIM_SHIFT;
	localparam int TQ_SHIFT = 18;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_PICKUP = 12'h004;
	localparam logic [11:0] OFF_TDIAL = 12'h008;
	localparam logic [11:0] OFF_MTA = 12'h00C;
	localparam logic [11:0] OFF_WORD = 12'h010;
	localparam logic [11:0] OFF_TORQUE = 12'h014;
	localparam logic [11:0] OFF_MASK_BASE = 12'h020;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_TOC_EN_BIT = 0;
	localparam int CTRL_DIR_SUP_BIT = 1;
	localparam int CTRL_CURVE_LSB = 4;
	localparam int CURVE_W = 2;
	localparam int MTA_SIN_LSB = 16;
	localparam int BIT_TOC_PICKUP = 0;
	localparam int BIT_TOC_TRIP = 1;
	localparam int BIT_FORWARD = 2;
	localparam int BIT_DIST_LSB = 3;
	localparam int DIST_W = 2;
	localparam int BIT_EXT_LSB = 5;
	localparam int EXT_W = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [MAG_W-1:0] PICKUP_RST = 16'h0100;
	localparam logic [TD_W-1:0] TDIAL_RST = 8'h10;
	localparam logic [MAG_W-1:0] MTA_COS_RST = 16'h7FFF;
	localparam logic [MAG_W-1:0] MTA_SIN_RST = 16'h0000;
	localparam logic [WORD_W-1:0] MASK_RST = 8'h00;

	typedef enum logic [CURVE_W-1:0] {
		REOML_MOD_INV,
		REOML_INV,
		REOML_VERY_INV,
		REOML_EXT_INV
	} reoml_curve_t;

	// ----------------------------------------------------------------
	// curve coefficients, seconds scaled to quarter cycles
	// ----------------------------------------------------------------
	localparam real POWER_HZ = 60.0;
	localparam real QC_PER_S = 4.0 * POWER_HZ;
	localparam real COEF_SCALE = QC_PER_S * (2.0 ** COEF_FRAC);
	localparam real A_MOD = 0.157;
	localparam real B_MOD = 0.668;
	localparam real A_INV = 0.180;
	localparam real B_INV = 5.95;
	localparam real A_VINV = 0.0963;
	localparam real B_VINV = 3.88;
	localparam real A_EINV = 0.0352;
	localparam real B_EINV = 5.67;
	localparam logic [COEF_W-1:0] A_MOD_Q = COEF_W'(int'(A_MOD * COEF_SCALE));
	localparam logic [COEF_W-1:0] B_MOD_Q = COEF_W'(int'(B_MOD * COEF_SCALE));
	localparam logic [COEF_W-1:0] A_INV_Q = COEF_W'(int'(A_INV * COEF_SCALE));
	localparam logic [COEF_W-1:0] B_INV_Q = COEF_W'(int'(B_INV * COEF_SCALE));
	localparam logic [COEF_W-1:0] A_VINV_Q = COEF_W'(int'(A_VINV * COEF_SCALE));
	localparam logic [COEF_W-1:0] B_VINV_Q = COEF_W'(int'(B_VINV * COEF_SCALE));
	localparam logic [COEF_W-1:0] A_EINV_Q = COEF_W'(int'(A_EINV * COEF_SCALE));
	localparam logic [COEF_W-1:0] B_EINV_Q = COEF_W'(int'(B_EINV * COEF_SCALE));

endpackage

// ==== src/reoml_mask_or.sv ====
// Purpose: one output's mask gate over the element-state word
// Assumes: word and mask on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
module reoml_mask_or #(
	parameter int WIDTH = 8
)(
	input wire logic [WIDTH-1:0] word,
	input wire logic [WIDTH-1:0] mask,
	output logic hit
);

	// ----------------------------------------------------------------
	// and then or
	// ----------------------------------------------------------------
	assign hit = |(word & mask);

endmodule

// ==== src/reoml_dir.sv ====
// Purpose: negative-sequence directional torque and forward decision
// Assumes: phasors refreshed with sample, mta given as cos and sin q15
// Notes: torque is the real part of -v2 * conj(i2) * exp(-j mta)
`timescale 1ns/1ps
module reoml_dir (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sample,
	input wire logic signed [15:0] v2_re,
	input wire logic signed [15:0] v2_im,
	input wire logic signed [15:0] i2_re,
	input wire logic signed [15:0] i2_im,
	input wire logic signed [15:0] mta_cos,
	input wire logic signed [15:0] mta_sin,
	output logic signed [49:0] torque,
	output logic forward
);

	typedef struct packed {
		logic signed [49:0] torque;
		logic forward;
	} reoml_dir_state_t;

	reoml_dir_state_t s;
	reoml_dir_state_t next_s;
	logic signed [32:0] p_re;
	logic signed [32:0] p_im;
	logic signed [49:0] t;

	// ----------------------------------------------------------------
	// torque product
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		p_re = -(33'(v2_re * i2_re) + 33'(v2_im * i2_im));
		p_im = 33'(v2_re * i2_im) - 33'(v2_im * i2_re);
		t = 50'(p_re * mta_cos) + 50'(p_im * mta_sin);
		if (sample)
		begin
			next_s.torque = t;
			next_s.forward = (t > 50'sd0);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign torque = s.torque;
	assign forward = s.forward;

endmodule

// ==== src/reoml_top.sv ====
// Purpose: residual time-overcurrent, directional supervision and
//          per-output mask logic behind an APB slave
// Assumes: qc_tick pulses once per quarter power cycle with fresh phasors
// Notes: masks load from stored settings by software after power-up
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Function
// - overcurrent nondirectional or forward-only by enable
// - pickup and trip selectable; pickup in word
// - four curve shapes plus time dial
// - recursive sum of magnitude or squared magnitude
// - trip when sum reaches dial-derived limit
// - moderately inverse: dial times 0.157 plus 0.668/(m-1)
// - inverse: dial times 0.180 plus 5.95/(m2-1)
// - very inverse: dial times 0.0963 plus 3.88/(m2-1)
// - extremely inverse: dial times 0.0352 plus 5.67/(m2-1)
// - directional always gates distance, optionally overcurrent
// - forward when current leads within 90 degrees
// - torque from magnitudes and cosine; positive forward
// - one word bit per element, 1 picked up
// - output is or of word and mask
// - word refreshed each quarter cycle; masks fixed
// - separate mask for trip and each contact
// - masks kept as stored settings
// - phasors taken four times per cycle
module reoml_top #(
	parameter int NUM_OUTS = reoml_pkg::NUM_OUTS
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [reoml_pkg::ADDR_W-1:0] paddr,
	input wire logic [reoml_pkg::DATA_W-1:0] pwdata,
	output logic [reoml_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic qc_tick,
	input wire logic [reoml_pkg::MAG_W-1:0] resid_mag,
	input wire logic signed [15:0] negseq_voltage_re,
	input wire logic signed [15:0] negseq_voltage_im,
	input wire logic signed [15:0] negseq_current_re,
	input wire logic signed [15:0] negseq_current_im,
	input wire logic [reoml_pkg::DIST_W-1:0] dist_raw,
	input wire logic [reoml_pkg::EXT_W-1:0] ext_elements,
	output logic trip_out,
	output logic [NUM_OUTS-1:0] contact_out,
	output logic [reoml_pkg::WORD_W-1:0] element_word
);

	localparam int WW = reoml_pkg::WORD_W;
	localparam int MW = reoml_pkg::MAG_W;
	localparam int AW = reoml_pkg::ACC_W;
	localparam int CW = reoml_pkg::COEF_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic toc_en;
		logic dir_sup;
		reoml_pkg::reoml_curve_t curve;
		logic [MW-1:0] pickup;
		logic [reoml_pkg::TD_W-1:0] time_dial_setting;
		logic [MW-1:0] mta_cos;
		logic [MW-1:0] mta_sin;
		logic [NUM_OUTS:0][WW-1:0] masks;
		logic [AW-1:0] acc;
		logic residual_toc_pickup_bit;
		logic residual_toc_trip_bit;
		logic [WW-1:0] word;
		logic trip;
		logic [NUM_OUTS-1:0] contacts;
		logic [reoml_pkg::DATA_W-1:0] prdata;
		logic pslverr;
	} reoml_state_t;

	reoml_state_t s;
	reoml_state_t next_s;

	logic fwd;
	logic signed [49:0] torque;
	logic [NUM_OUTS:0] hits;

	// ----------------------------------------------------------------
	// directional element
	// ----------------------------------------------------------------
	reoml_dir u_dir (
		.pclk(pclk),
		.presetn(presetn),
		.sample(qc_tick),
		.v2_re(negseq_voltage_re),
		.v2_im(negseq_voltage_im),
		.i2_re(negseq_current_re),
		.i2_im(negseq_current_im),
		.mta_cos(s.mta_cos),
		.mta_sin(s.mta_sin),
		.torque(torque),
		.forward(fwd)
	);

	// ----------------------------------------------------------------
	// one mask gate per output, index 0 is trip
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g <= NUM_OUTS; g++)
		begin : g_mask
			reoml_mask_or #(
				.WIDTH(WW)
			) u_mask (
				.word(s.word),
				.mask(s.masks[g]),
				.hit(hits[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic above;
	logic [31:0] sq;
	logic [31:0] inc;
	logic [31:0] refv;
	logic [CW-1:0] a_c;
	logic [CW-1:0] b_c;
	logic [63:0] prod;
	logic [AW-1:0] limit;
	logic [AW:0] acc_wide;
	logic [AW-1:0] acc_sum;
	logic [reoml_pkg::DATA_W-1:0] rd;
	logic hit_addr;
	logic [WW-1:0] new_word;

	always_comb
	begin
		next_s = s;
		above = 1'b0;
		rd = '0;
		hit_addr = 1'b0;
		new_word = s.word;
		sq = 32'(resid_mag) * 32'(resid_mag);

		// curve selection
		case (s.curve)
			reoml_pkg::REOML_MOD_INV:
			begin
				a_c = reoml_pkg::A_MOD_Q;
				b_c = reoml_pkg::B_MOD_Q;
			end
			reoml_pkg::REOML_INV:
			begin
				a_c = reoml_pkg::A_INV_Q;
				b_c = reoml_pkg::B_INV_Q;
			end
			reoml_pkg::REOML_VERY_INV:
			begin
				a_c = reoml_pkg::A_VINV_Q;
				b_c = reoml_pkg::B_VINV_Q;
			end
			default:
			begin
				a_c = reoml_pkg::A_EINV_Q;
				b_c = reoml_pkg::B_EINV_Q;
			end
		endcase

		// increment: magnitude or squared magnitude over pickup
		if (s.curve == reoml_pkg::REOML_MOD_INV)
		begin
			inc = 32'(resid_mag) - 32'(s.pickup);
			refv = 32'(s.pickup);
		end
		else
		begin
			inc = sq - 32'(s.pickup) * 32'(s.pickup);
			refv = 32'(s.pickup) * 32'(s.pickup);
		end

		// limit = dial * (a * inc + b * ref), so n >= dial*(a + b/(m-1)), or dial*(a + b/(m2-1)) on the squared curves
		prod = 64'(s.time_dial_setting) *
			(64'(a_c) * 64'(inc) + 64'(b_c) * 64'(refv));
		limit = prod[63:reoml_pkg::LIM_SHIFT];
		acc_wide = {1'b0, s.acc} + (AW+1)'(inc);
		acc_sum = acc_wide[AW] ? '1 : acc_wide[AW-1:0];

		// --------------------------------------------------------
		// register writes in the access phase
		// --------------------------------------------------------
		if (psel && penable && pwrite)
		begin
			if (paddr == reoml_pkg::OFF_CTRL)
			begin
				next_s.toc_en = pwdata[reoml_pkg::CTRL_TOC_EN_BIT];
				next_s.dir_sup = pwdata[reoml_pkg::CTRL_DIR_SUP_BIT];
				next_s.curve = reoml_pkg::reoml_curve_t'(
					pwdata[reoml_pkg::CTRL_CURVE_LSB +: reoml_pkg::CURVE_W]);
			end
			else if (paddr == reoml_pkg::OFF_PICKUP)
				next_s.pickup = pwdata[MW-1:0];
			else if (paddr == reoml_pkg::OFF_TDIAL)
				next_s.time_dial_setting = pwdata[reoml_pkg::TD_W-1:0];
			else if (paddr == reoml_pkg::OFF_MTA)
			begin
				next_s.mta_cos = pwdata[MW-1:0];
				next_s.mta_sin = pwdata[reoml_pkg::MTA_SIN_LSB +: MW];
			end
			else
			begin
				for (int k = 0; k <= NUM_OUTS; k++)
				begin
					// masks change only here, on any mask write, even one in a qc_tick cycle
					if (paddr == 12'(int'(reoml_pkg::OFF_MASK_BASE) + 4 * k))
						next_s.masks[k] = pwdata[WW-1:0];
				end
			end
		end

		// --------------------------------------------------------
		// read data and error captured in the setup phase
		// --------------------------------------------------------
		if (psel && !penable)
		begin
			if (paddr == reoml_pkg::OFF_CTRL)
			begin
				hit_addr = 1'b1;
				rd[reoml_pkg::CTRL_TOC_EN_BIT] = s.toc_en;
				rd[reoml_pkg::CTRL_DIR_SUP_BIT] = s.dir_sup;
				rd[reoml_pkg::CTRL_CURVE_LSB +: reoml_pkg::CURVE_W] = s.curve;
			end
			else if (paddr == reoml_pkg::OFF_PICKUP)
			begin
				hit_addr = 1'b1;
				rd[MW-1:0] = s.pickup;
			end
			else if (paddr == reoml_pkg::OFF_TDIAL)
			begin
				hit_addr = 1'b1;
				rd[reoml_pkg::TD_W-1:0] = s.time_dial_setting;
			end
			else if (paddr == reoml_pkg::OFF_MTA)
			begin
				hit_addr = 1'b1;
				rd = {s.mta_sin, s.mta_cos};
			end
			else if (paddr == reoml_pkg::OFF_WORD)
			begin
				hit_addr = 1'b1;
				rd[WW-1:0] = s.word;
			end
			else if (paddr == reoml_pkg::OFF_TORQUE)
			begin
				hit_addr = 1'b1;
				rd = torque[reoml_pkg::TQ_SHIFT +: reoml_pkg::DATA_W];
			end
			else
			begin
				for (int k = 0; k <= NUM_OUTS; k++)
				begin
					if (paddr == 12'(int'(reoml_pkg::OFF_MASK_BASE) + 4 * k))
					begin
						hit_addr = 1'b1;
						rd[WW-1:0] = s.masks[k];
					end
				end
			end
			next_s.prdata = rd;
			next_s.pslverr = !hit_addr;
		end

		// --------------------------------------------------------
		// overcurrent and word refresh on each quarter cycle
		// --------------------------------------------------------
		if (qc_tick)
		begin
			above = s.toc_en && (resid_mag > s.pickup) &&
				(!s.dir_sup || fwd);
			if (!above)
			begin
				next_s.acc = '0;
				next_s.residual_toc_pickup_bit = 1'b0;
				next_s.residual_toc_trip_bit = 1'b0;
			end
			else
			begin
				next_s.acc = acc_sum;
				next_s.residual_toc_pickup_bit = 1'b1;
				next_s.residual_toc_trip_bit = s.residual_toc_trip_bit ||
					(acc_sum >= limit);
			end
			new_word = '0;
			new_word[reoml_pkg::BIT_TOC_PICKUP] =
				next_s.residual_toc_pickup_bit;
			new_word[reoml_pkg::BIT_TOC_TRIP] =
				next_s.residual_toc_trip_bit;
			new_word[reoml_pkg::BIT_FORWARD] = fwd;
			new_word[reoml_pkg::BIT_DIST_LSB +: reoml_pkg::DIST_W] =
				dist_raw & {reoml_pkg::DIST_W{fwd}};
			new_word[reoml_pkg::BIT_EXT_LSB +: reoml_pkg::EXT_W] =
				ext_elements;
			next_s.word = new_word;
		end

		// --------------------------------------------------------
		// contact drive from mask gates
		// --------------------------------------------------------
		next_s.trip = hits[0];
		next_s.contacts = hits[NUM_OUTS:1];
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.curve <= reoml_pkg::REOML_MOD_INV;
			s.pickup <= reoml_pkg::PICKUP_RST;
			s.time_dial_setting <= reoml_pkg::TDIAL_RST;
			s.mta_cos <= reoml_pkg::MTA_COS_RST;
			s.mta_sin <= reoml_pkg::MTA_SIN_RST;
			s.masks <= {(NUM_OUTS + 1){reoml_pkg::MASK_RST}};
		end
		else
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = s.pslverr;
	assign trip_out = s.trip;
	assign contact_out = s.contacts;
	assign element_word = s.word;

endmodule

// ==== testbench/reoml_top_assertions.sv ====
// Purpose: port checks for reoml_top
// Assumes: one pclk domain, presetn async active low
// Notes: bound into every reoml_top below the module
`timescale 1ns/1ps
module reoml_top_chk #(
	parameter int NUM_OUTS = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic qc_tick,
	input wire logic [2:0] ext_elements,
	input wire logic trip_out,
	input wire logic [NUM_OUTS-1:0] contact_out,
	input wire logic [7:0] element_word
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_word_tick: assert property (
		$changed(element_word) |-> $past(qc_tick))
		else $error("word changed without a tick");
	a_ext_taken: assert property (
		qc_tick |=> element_word[7:5] == $past(ext_elements))
		else $error("element bits not taken at tick");
	a_trip_pickup: assert property (
		element_word[1] |-> element_word[0])
		else $error("trip bit without pickup bit");
	a_dist_gated: assert property (
		(|element_word[4:3]) |-> element_word[2])
		else $error("distance bit without forward");
	a_trip_word: assert property (
		trip_out |-> $past(element_word) != 8'h00)
		else $error("trip with empty word");
	a_contact_word: assert property (
		(|contact_out) |-> $past(element_word) != 8'h00)
		else $error("contact with empty word");
	a_trip_cause: assert property (
		$changed(trip_out) |-> $past(element_word) !=
		$past(element_word, 2) || $past(psel && penable && pwrite))
		else $error("trip moved without cause");
	a_contact_cause: assert property (
		$changed(contact_out) |-> $past(element_word) !=
		$past(element_word, 2) || $past(psel && penable && pwrite))
		else $error("contact moved without cause");
endmodule

bind reoml_top reoml_top_chk #(.NUM_OUTS(NUM_OUTS)) u_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .qc_tick, .ext_elements, .trip_out,
	.contact_out, .element_word);

// ==== testbench/reoml_breaker_model.sv ====
// Purpose: breaker trip circuit beside reoml_top
// Assumes: trip_out is an active high level
// Notes: breaker seals open on trip until reset
`timescale 1ns/1ps
module reoml_breaker_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic trip_out,
	output logic breaker_open
);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			breaker_open <= 1'h0;
		else if (trip_out)
			breaker_open <= 1'h1;
	end
endmodule

// ==== testbench/tb_reoml_top.sv ====
// Purpose: self-checking bench for reoml_top
// Assumes: APB master in the bench, zero wait answers
// Notes: tick spacing kept at two cycles or more
`timescale 1ns/1ps
module tb_reoml_top;
	typedef struct packed {
		logic [2:0] ext;
		logic [7:0] tm;
		logic tr;
		logic [3:0] co;
	} reoml_row_t;
	logic pclk, pready, pslverr, trip_out, breaker_open, err;
	logic presetn = 0, psel = 0, penable = 0, pwrite = 0, qc_tick = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [15:0] resid_mag = 0;
	logic signed [15:0] vre = 0, vim = 0, cre = 0, cim = 0;
	logic [1:0] dist_raw = 0;
	logic [2:0] ext_elements = 0;
	logic [3:0] contact_out;
	logic [7:0] element_word;
	int fail_count = 0, total_checks = 0, n;
	real e;
	real ta [4] = '{0.157, 0.180, 0.0963, 0.0352};
	real tb [4] = '{0.668, 5.95, 3.88, 5.67};
	logic [1:0] cv [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	logic [7:0] dl [5] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h20};
	logic signed [15:0] dvr [4] = '{-16'sd1000, -16'sd1000, -16'sd1000,
		16'sd1000};
	logic signed [15:0] dcr [4] = '{16'sd1000, 16'sd0, 16'sd10, 16'sd1000};
	logic signed [15:0] dci [4] = '{16'sd0, 16'sd1000, 16'sd1000, 16'sd0};
	logic fw [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
	logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h020,
		12'h030, 12'h010};
	logic [31:0] rv [7] = '{32'h0, 32'h100, 32'h10, 32'h7FFF, 32'h0,
		32'h0, 32'h0};
	reoml_row_t rows [5] = '{'{3'h1, 8'h22, 1'h1, 4'h1},
		'{3'h2, 8'h22, 1'h0, 4'h2}, '{3'h4, 8'h9F, 1'h1, 4'h4},
		'{3'h0, 8'hFF, 1'h0, 4'h0}, '{3'h7, 8'h1F, 1'h0, 4'h7}};

	reoml_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .qc_tick, .resid_mag,
		.negseq_voltage_re(vre), .negseq_voltage_im(vim),
		.negseq_current_re(cre), .negseq_current_im(cim), .dist_raw,
		.ext_elements, .trip_out, .contact_out, .element_word);
	reoml_breaker_model u_brk (.pclk, .presetn, .trip_out, .breaker_open);

	initial
	begin
		pclk = 0;
		forever #20 pclk = ~pclk;
	end

	task chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x)
		begin
			fail_count++;
			$display("FAIL %0t seen %h want %h", $time, s, x);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task tick(input int m);
		repeat (m)
		begin
			@(posedge pclk);
			qc_tick <= 1'h1;
			@(posedge pclk);
			qc_tick <= 1'h0;
		end
		@(posedge pclk);
		#1;
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		print_verdict;
	end

	initial
	begin
		repeat (12) @(posedge pclk);
		chk({trip_out, contact_out, element_word}, 0);
		presetn <= 1'h1;
		for (int k = 0; k < 4; k++)
			apb(1, 12'h024 + 12'(4 * k), (32'h20 << k) & 32'hFF);
		foreach (rows[i])
		begin
			apb(1, 12'h020, rows[i].tm);
			ext_elements <= rows[i].ext;
			tick(1);
			chk(element_word, {rows[i].ext, 5'h00});
			chk(trip_out, rows[i].tr);
			chk(contact_out, rows[i].co);
		end
		ext_elements <= 3'h0;
		apb(1, 12'h020, 32'h02);
		apb(1, 12'h030, 32'h01);
		for (int c = 0; c < 5; c++)
		begin
			apb(1, 12'h008, dl[c]);
			apb(1, 12'h000, {cv[c], 4'h1});
			resid_mag <= 16'h0200;
			n = 0;
			do
			begin
				tick(1);
				n++;
				if (n == 1)
					chk(contact_out[3], 1);
			end
			while (element_word[1] !== 1'h1 && n < 700);
			e = 240.0 * (ta[cv[c]] + tb[cv[c]] / (cv[c] == 0 ? 1.0 : 3.0));
			e = e * dl[c] / 16.0;
			chk(n > e - 2.5 && n < e + 2.5, 1);
			chk(trip_out, 1);
			resid_mag <= 16'h0100;
			tick(1);
			chk({trip_out, element_word[1:0]}, 0);
		end
		chk(breaker_open, 1);
		apb(1, 12'h000, 32'h3);
		resid_mag <= 16'h0200;
		dist_raw <= 2'h3;
		for (int c = 0; c < 4; c++)
		begin
			vre <= dvr[c];
			cre <= dcr[c];
			cim <= dci[c];
			tick(3);
			chk(element_word[4:0], fw[c] ? 5'h1D : 5'h00);
		end
		apb(1, 12'h000, 32'h1);
		tick(1);
		chk(element_word[4:0], 5'h01);
		apb(1, 12'h00C, 32'h7FFF0000);
		vre <= -16'sd1000;
		cre <= 16'sd0;
		cim <= -16'sd1000;
		tick(3);
		chk(element_word[4:0], 5'h1D);
		apb(0, 12'h014, 32'h0);
		chk(rd, 32'((64'hF4240 * 64'h7FFF) >> 18));
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk({trip_out, contact_out, element_word, breaker_open}, 0);
		presetn <= 1'h1;
		apb(1, 12'h018, 32'hFF);
		chk(err, 1);
		apb(1, 12'h010, 32'hFF);
		chk(err, 0);
		foreach (ra[i])
		begin
			apb(0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(0, 12'h018, 32'h0);
		chk({err, rd}, {1'h1, 32'h0});
		print_verdict;
	end
endmodule
